// ### logic/mcc_pkg.sv
// What this block does
// - raw cell count minus stored offset trim, uncorrected
// - written calibration gain overrides factory or default
// - order is trim, gain, then offset
// - five cell gains, gain n for input n
// - cell millivolts equal gain times count over 65536, minus offset
// - stack, pack, load use own gain, divider offset
// - analog input voltage has no offset subtracted
// - unrestricted mode cell gain reads give factory gain if unwritten
// - update mode reads zero or written; after, cell gain reads give gain in use
// - nominal gains 12120 cell, 4040 analog input
// - calibration readout returns raw divider counts
// - extended status gives raw 32-bit pin counts
// - overvoltage search stores coefficient in override
// - undervoltage search stores coefficient in override
// - nonzero override replaces factory threshold trim
// - current is raw minus offset per sample, times gain
// - current and capacity gains are single floats
// - capacity gain is current gain times fixed constant
package mcc_pkg;
  // register byte addresses
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_CELL_GAIN0 = 12'h010; // five words, 0x010..0x020
  localparam logic [11:0] ADDR_STACK_GAIN = 12'h030;
  localparam logic [11:0] ADDR_PACK_GAIN = 12'h034;
  localparam logic [11:0] ADDR_LOAD_GAIN = 12'h038;
  localparam logic [11:0] ADDR_ADC_GAIN = 12'h03c;
  localparam logic [11:0] ADDR_VCELL_OFS = 12'h040;
  localparam logic [11:0] ADDR_VDIV_OFS = 12'h044;
  localparam logic [11:0] ADDR_BOARD_OFS = 12'h048;
  localparam logic [11:0] ADDR_OFS_SAMPLES = 12'h04c;
  localparam logic [11:0] ADDR_CUR_GAIN = 12'h050;
  localparam logic [11:0] ADDR_CAP_GAIN = 12'h054;
  localparam logic [11:0] ADDR_OV_OVERRIDE = 12'h058;
  localparam logic [11:0] ADDR_UV_OVERRIDE = 12'h05c;
  localparam logic [11:0] ADDR_OV_IN_USE = 12'h060;
  localparam logic [11:0] ADDR_UV_IN_USE = 12'h064;
  localparam logic [11:0] ADDR_CAL_RESULT = 12'h068;
  localparam logic [11:0] ADDR_CELL_V0 = 12'h080; // five words, 0x080..0x090
  localparam logic [11:0] ADDR_CELL_RAW0 = 12'h0a0; // five words, 0x0a0..0x0b0
  localparam logic [11:0] ADDR_STACK_V = 12'h0c0;
  localparam logic [11:0] ADDR_PACK_V = 12'h0c4;
  localparam logic [11:0] ADDR_LOAD_V = 12'h0c8;
  localparam logic [11:0] ADDR_ADC_V = 12'h0cc;
  localparam logic [11:0] ADDR_CURRENT = 12'h0d0;
  localparam logic [11:0] ADDR_READOUT0 = 12'h0e0; // stack, pack, load raw counts
  localparam logic [11:0] ADDR_EXT_RAW0 = 12'h100; // five pin raw counts
  // control fields
  localparam int CTRL_UPDATE_MODE = 0;
  localparam int CTRL_FULL_ACCESS = 1;
  localparam int CTRL_CAL_OV = 2;
  localparam int CTRL_CAL_UV = 3;
  // status fields
  localparam int STAT_BUSY = 0;
  localparam int STAT_DONE = 1;
  // nominal gains and constants
  localparam logic [15:0] CELL_GAIN_NOMINAL = 16'h2f58; // 12120
  localparam logic [15:0] ADC_GAIN_NOMINAL = 16'h0fc8; // 4040
  localparam logic [15:0] DIV_GAIN_DEFAULT = 16'h2f58;
  localparam int GAIN_SHIFT = 16; // divide by 65536
  localparam logic [31:0] CUR_GAIN_DEFAULT = 32'h3f800000; // 1.0
  localparam logic [31:0] CAP_GAIN_FACTOR = 32'h4891a2b4; // 298261.6178
  localparam logic [7:0] THRESH_BITS = 8'h08;
  localparam int N_CELL = 5;
  localparam int N_PIN = 5;
  // search states
  typedef enum logic [2:0] {
    MCC_IDLE = 3'b001,
    MCC_STEP = 3'b010,
    MCC_DONE = 3'b100
  } mcc_state_t;
endpackage

// ### logic/mcc_core.sv
// Chosen here: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
module mcc_core #(
  parameter logic [7:0] OV_FACTORY_TRIM = 8'h80,
  parameter logic [7:0] UV_FACTORY_TRIM = 8'h40,
  parameter logic [15:0] CELL_FACTORY_GAIN = 16'h2f58
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // raw converter inputs
  input wire logic meas_valid,
  input wire logic [31:0] cell_raw_count [5],
  input wire logic [31:0] cell_offset_trim,
  input wire logic [15:0] cell_count [5],
  input wire logic [15:0] stack_count,
  input wire logic [15:0] pack_count,
  input wire logic [15:0] load_count,
  input wire logic [15:0] adc_count,
  input wire logic [31:0] pin_raw_count [5],
  input wire logic [31:0] current_raw,
  // float multiplier result from the shared arithmetic unit
  output logic [31:0] float_a,
  output logic [31:0] float_b,
  input wire logic [31:0] float_product,
  // protection comparator used by the threshold search
  output logic [7:0] ov_threshold_coef,
  output logic [7:0] uv_threshold_coef,
  input wire logic cmp_trip
);
  logic [31:0] ctrl;
  logic [15:0] cell_gain [5];
  logic [4:0] cell_gain_written;
  logic [15:0] stack_gain, pack_gain, load_gain, adc_gain;
  logic [3:0] div_written;
  logic signed [15:0] vcell_ofs, vdiv_ofs;
  logic signed [31:0] board_ofs;
  logic [15:0] ofs_samples;
  logic [31:0] cur_gain, cap_gain;
  logic [7:0] ov_override, uv_override;
  logic [7:0] cal_coef, cal_bit;
  logic cal_is_ov, cal_done;
  mcc_pkg::mcc_state_t state;
  logic signed [15:0] cell_v [5];
  logic [31:0] cell_rep [5];
  logic signed [15:0] stack_v, pack_v, load_v, adc_v;
  logic signed [31:0] current_fixed;
  logic [31:0] current_out;
  logic wr, rd;
  logic update_mode_q;

  assign wr = psel && penable && pwrite;
  assign rd = psel && !penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = 1'b0;

  // effective gains: written value, else factory or default
  function automatic logic [15:0] pick(input logic w, input logic [15:0] v,
                                       input logic [15:0] d);
    pick = w ? v : d;
  endfunction

  // scaled value: signed product shifted right, floor rounding
  function automatic logic signed [15:0] scale(input logic [15:0] g, input logic [15:0] c);
    logic signed [33:0] p;
    p = $signed({2'b00, g}) * $signed({2'b00, c});
    scale = 16'(p >>> mcc_pkg::GAIN_SHIFT);
  endfunction

  // control register and calibration parameters
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= 32'h0;
      cell_gain_written <= 5'h0;
      div_written <= 4'h0;
      stack_gain <= 16'h0;
      pack_gain <= 16'h0;
      load_gain <= 16'h0;
      adc_gain <= 16'h0;
      vcell_ofs <= 16'sh0;
      vdiv_ofs <= 16'sh0;
      board_ofs <= 32'sh0;
      ofs_samples <= 16'h1;
      cur_gain <= mcc_pkg::CUR_GAIN_DEFAULT;
      for (int i = 0; i < mcc_pkg::N_CELL; i++) begin
        cell_gain[i] <= 16'h0;
      end
    end else begin
      ctrl[mcc_pkg::CTRL_CAL_OV] <= 1'b0;
      ctrl[mcc_pkg::CTRL_CAL_UV] <= 1'b0;
      if (wr) begin
        unique case (paddr)
          mcc_pkg::ADDR_CTRL: ctrl <= pwdata;
          mcc_pkg::ADDR_STACK_GAIN: begin
            stack_gain <= pwdata[15:0];
            div_written[0] <= 1'b1;
          end
          mcc_pkg::ADDR_PACK_GAIN: begin
            pack_gain <= pwdata[15:0];
            div_written[1] <= 1'b1;
          end
          mcc_pkg::ADDR_LOAD_GAIN: begin
            load_gain <= pwdata[15:0];
            div_written[2] <= 1'b1;
          end
          mcc_pkg::ADDR_ADC_GAIN: begin
            adc_gain <= pwdata[15:0];
            div_written[3] <= 1'b1;
          end
          mcc_pkg::ADDR_VCELL_OFS: vcell_ofs <= pwdata[15:0];
          mcc_pkg::ADDR_VDIV_OFS: vdiv_ofs <= pwdata[15:0];
          mcc_pkg::ADDR_BOARD_OFS: board_ofs <= pwdata;
          mcc_pkg::ADDR_OFS_SAMPLES: ofs_samples <= (pwdata[15:0] == 16'h0) ? 16'h1 : pwdata[15:0];
          mcc_pkg::ADDR_CUR_GAIN: cur_gain <= pwdata;
          default: begin
            for (int i = 0; i < mcc_pkg::N_CELL; i++) begin
              if (paddr == mcc_pkg::ADDR_CELL_GAIN0 + 12'(4 * i)) begin
                cell_gain[i] <= pwdata[15:0];
                cell_gain_written[i] <= 1'b1;
              end
            end
          end
        endcase
      end
    end
  end

  // capacity gain tracks current gain through the shared multiplier
  assign float_a = cur_gain;
  assign float_b = mcc_pkg::CAP_GAIN_FACTOR;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_gain <= 32'h0;
    end else begin
      cap_gain <= float_product;
    end
  end

  // corrected measurements, recomputed on each new conversion
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stack_v <= 16'sh0;
      pack_v <= 16'sh0;
      load_v <= 16'sh0;
      adc_v <= 16'sh0;
      current_fixed <= 32'sh0;
      for (int i = 0; i < mcc_pkg::N_CELL; i++) begin
        cell_v[i] <= 16'sh0;
        cell_rep[i] <= 32'h0;
      end
    end else if (meas_valid) begin
      for (int i = 0; i < mcc_pkg::N_CELL; i++) begin
        cell_rep[i] <= cell_raw_count[i] - cell_offset_trim;
        cell_v[i] <= scale(pick(cell_gain_written[i], cell_gain[i], CELL_FACTORY_GAIN),
                           cell_count[i]) - vcell_ofs;
      end
      stack_v <= scale(pick(div_written[0], stack_gain, mcc_pkg::DIV_GAIN_DEFAULT),
                       stack_count) - vdiv_ofs;
      pack_v <= scale(pick(div_written[1], pack_gain, mcc_pkg::DIV_GAIN_DEFAULT),
                      pack_count) - vdiv_ofs;
      load_v <= scale(pick(div_written[2], load_gain, mcc_pkg::DIV_GAIN_DEFAULT),
                      load_count) - vdiv_ofs;
      adc_v <= scale(pick(div_written[3], adc_gain, mcc_pkg::ADC_GAIN_NOMINAL),
                     adc_count);
      current_fixed <= $signed(current_raw) - board_ofs / $signed({16'h0, ofs_samples});
    end
  end

  // offset-corrected current times float gain: gain applied as mantissa scale
  always_comb begin
    logic signed [55:0] p;
    logic [7:0] e;
    p = 56'(current_fixed) * $signed({32'h0, 1'b1, cur_gain[22:0]});
    e = cur_gain[30:23];
    current_out = 32'(p >>> (8'd150 - e));
    if (cur_gain[31]) begin
      current_out = -current_out;
    end
  end

  // threshold search: binary search on comparator trip, msb first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= mcc_pkg::MCC_IDLE;
      cal_coef <= 8'h0;
      cal_bit <= 8'h0;
      cal_is_ov <= 1'b0;
      cal_done <= 1'b0;
      ov_override <= 8'h0;
      uv_override <= 8'h0;
    end else begin
      unique case (state)
        mcc_pkg::MCC_IDLE: begin
          if (ctrl[mcc_pkg::CTRL_UPDATE_MODE] &&
              (ctrl[mcc_pkg::CTRL_CAL_OV] || ctrl[mcc_pkg::CTRL_CAL_UV])) begin
            cal_is_ov <= ctrl[mcc_pkg::CTRL_CAL_OV];
            cal_coef <= 8'h80;
            cal_bit <= 8'h80;
            cal_done <= 1'b0;
            state <= mcc_pkg::MCC_STEP;
          end else if (wr && paddr == mcc_pkg::ADDR_OV_OVERRIDE) begin
            ov_override <= pwdata[7:0];
          end else if (wr && paddr == mcc_pkg::ADDR_UV_OVERRIDE) begin
            uv_override <= pwdata[7:0];
          end
        end
        mcc_pkg::MCC_STEP: begin
          // overvoltage trip lowers the trial code, undervoltage trip raises it
          if (cmp_trip == cal_is_ov) begin
            cal_coef <= (cal_coef & ~cal_bit) | (cal_bit >> 1);
          end else begin
            cal_coef <= cal_coef | (cal_bit >> 1);
          end
          cal_bit <= cal_bit >> 1;
          if (cal_bit == 8'h01) begin
            state <= mcc_pkg::MCC_DONE;
          end
        end
        mcc_pkg::MCC_DONE: begin
          if (cal_is_ov) begin
            ov_override <= cal_coef;
          end else begin
            uv_override <= cal_coef;
          end
          cal_done <= 1'b1;
          state <= mcc_pkg::MCC_IDLE;
        end
      endcase
    end
  end

  // coefficients in use: trial code for the searched side during search, else override when nonzero
  always_comb begin
    ov_threshold_coef = (ov_override != 8'h0) ? ov_override : OV_FACTORY_TRIM;
    uv_threshold_coef = (uv_override != 8'h0) ? uv_override : UV_FACTORY_TRIM;
    if (state == mcc_pkg::MCC_STEP) begin
      if (cal_is_ov) begin
        ov_threshold_coef = cal_coef;
      end else begin
        uv_threshold_coef = cal_coef;
      end
    end
  end

  // mode flag kept for read qualification
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      update_mode_q <= 1'b0;
    end else begin
      update_mode_q <= ctrl[mcc_pkg::CTRL_UPDATE_MODE];
    end
  end

  // read data, latched during the setup phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (rd) begin
      prdata <= 32'h0;
      unique case (paddr)
        mcc_pkg::ADDR_CTRL: prdata <= ctrl;
        mcc_pkg::ADDR_STATUS:
          prdata <= {30'h0, cal_done, state == mcc_pkg::MCC_STEP};
        mcc_pkg::ADDR_STACK_GAIN: prdata <= {16'h0, stack_gain};
        mcc_pkg::ADDR_PACK_GAIN: prdata <= {16'h0, pack_gain};
        mcc_pkg::ADDR_LOAD_GAIN: prdata <= {16'h0, load_gain};
        mcc_pkg::ADDR_ADC_GAIN: prdata <= {16'h0, adc_gain};
        mcc_pkg::ADDR_VCELL_OFS: prdata <= {{16{vcell_ofs[15]}}, vcell_ofs};
        mcc_pkg::ADDR_VDIV_OFS: prdata <= {{16{vdiv_ofs[15]}}, vdiv_ofs};
        mcc_pkg::ADDR_BOARD_OFS: prdata <= board_ofs;
        mcc_pkg::ADDR_OFS_SAMPLES: prdata <= {16'h0, ofs_samples};
        mcc_pkg::ADDR_CUR_GAIN: prdata <= cur_gain;
        mcc_pkg::ADDR_CAP_GAIN: prdata <= cap_gain;
        mcc_pkg::ADDR_OV_OVERRIDE: prdata <= {24'h0, ov_override};
        mcc_pkg::ADDR_UV_OVERRIDE: prdata <= {24'h0, uv_override};
        mcc_pkg::ADDR_OV_IN_USE: prdata <= {24'h0, ov_threshold_coef};
        mcc_pkg::ADDR_UV_IN_USE: prdata <= {24'h0, uv_threshold_coef};
        mcc_pkg::ADDR_CAL_RESULT: prdata <= {24'h0, cal_coef};
        mcc_pkg::ADDR_STACK_V: prdata <= {{16{stack_v[15]}}, stack_v};
        mcc_pkg::ADDR_PACK_V: prdata <= {{16{pack_v[15]}}, pack_v};
        mcc_pkg::ADDR_LOAD_V: prdata <= {{16{load_v[15]}}, load_v};
        mcc_pkg::ADDR_ADC_V: prdata <= {{16{adc_v[15]}}, adc_v};
        mcc_pkg::ADDR_CURRENT: prdata <= current_out;
        mcc_pkg::ADDR_READOUT0: prdata <= {16'h0, stack_count};
        mcc_pkg::ADDR_READOUT0 + 12'h004: prdata <= {16'h0, pack_count};
        mcc_pkg::ADDR_READOUT0 + 12'h008: prdata <= {16'h0, load_count};
        default: begin
          for (int i = 0; i < mcc_pkg::N_CELL; i++) begin
            if (paddr == mcc_pkg::ADDR_CELL_GAIN0 + 12'(4 * i)) begin
              if (update_mode_q) begin
                prdata <= cell_gain_written[i] ? {16'h0, cell_gain[i]} : 32'h0;
              end else begin
                prdata <= {16'h0, pick(cell_gain_written[i], cell_gain[i],
                                       CELL_FACTORY_GAIN)};
              end
            end
            if (paddr == mcc_pkg::ADDR_CELL_V0 + 12'(4 * i)) begin
              prdata <= {{16{cell_v[i][15]}}, cell_v[i]};
            end
            if (paddr == mcc_pkg::ADDR_CELL_RAW0 + 12'(4 * i)) begin
              prdata <= cell_rep[i];
            end
          end
          for (int i = 0; i < mcc_pkg::N_PIN; i++) begin
            if (paddr == mcc_pkg::ADDR_EXT_RAW0 + 12'(4 * i)) begin
              prdata <= pin_raw_count[i];
            end
          end
        end
      endcase
    end
  end
endmodule

// ### dv/mcc_chk.sv
`timescale 1ns/1ps
module mcc_chk #(
  parameter logic [7:0] OV_FACTORY_TRIM = 8'h80,
  parameter logic [7:0] UV_FACTORY_TRIM = 8'h40
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] float_a,
  input wire logic [31:0] float_b,
  input wire logic [7:0] ov_threshold_coef,
  input wire logic [7:0] uv_threshold_coef
);
  logic wr;
  logic ov_hit;
  logic uv_hit;
  logic cur_hit;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  assign wr = psel && penable && pwrite;
  // remember whether software ever touched a threshold or the current gain
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ov_hit <= 1'b0;
      uv_hit <= 1'b0;
      cur_hit <= 1'b0;
    end else if (wr) begin
      if (paddr == mcc_pkg::ADDR_OV_OVERRIDE || paddr == mcc_pkg::ADDR_CTRL) ov_hit <= 1'b1;
      if (paddr == mcc_pkg::ADDR_UV_OVERRIDE || paddr == mcc_pkg::ADDR_CTRL) uv_hit <= 1'b1;
      if (paddr == mcc_pkg::ADDR_CUR_GAIN) cur_hit <= 1'b1;
    end
  end
  // start of each threshold search
  sequence ov_start;
    wr && paddr == mcc_pkg::ADDR_CTRL && pwdata[mcc_pkg::CTRL_CAL_OV];
  endsequence
  sequence uv_start;
    wr && paddr == mcc_pkg::ADDR_CTRL && pwdata[mcc_pkg::CTRL_CAL_UV];
  endsequence
  zero_wait_a: assert property (psel && penable |-> pready)
    else $error("access not completed in first cycle");
  no_error_a: assert property (psel && penable |-> !pslverr)
    else $error("error response seen");
  prdata_hold_a: assert property ($changed(prdata) |-> $past(psel && !penable))
    else $error("read data moved outside a setup cycle");
  cap_factor_a: assert property (float_b == mcc_pkg::CAP_GAIN_FACTOR)
    else $error("capacity factor wrong");
  cur_default_a: assert property (!cur_hit |-> float_a == mcc_pkg::CUR_GAIN_DEFAULT)
    else $error("current gain not default");
  ov_factory_a: assert property (!ov_hit |-> ov_threshold_coef == OV_FACTORY_TRIM)
    else $error("overvoltage coefficient not factory");
  uv_factory_a: assert property (!uv_hit |-> uv_threshold_coef == UV_FACTORY_TRIM)
    else $error("undervoltage coefficient not factory");
  uv_quiet_a: assert property (ov_start |=> $stable(uv_threshold_coef) [*8])
    else $error("undervoltage coefficient moved in overvoltage search");
  ov_quiet_a: assert property (uv_start |=> $stable(ov_threshold_coef) [*8])
    else $error("overvoltage coefficient moved in undervoltage search");
endmodule
bind mcc_core mcc_chk #(.OV_FACTORY_TRIM(OV_FACTORY_TRIM), .UV_FACTORY_TRIM(UV_FACTORY_TRIM))
  chk_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .float_a(float_a), .float_b(float_b), .ov_threshold_coef(ov_threshold_coef),
  .uv_threshold_coef(uv_threshold_coef));

// ### dv/mcc_far_model.sv
`timescale 1ns/1ps
module mcc_far_model (
  input wire logic [31:0] float_a,
  input wire logic [31:0] float_b,
  input wire logic [7:0] ov_threshold_coef,
  input wire logic [7:0] uv_threshold_coef,
  input wire logic [7:0] target,
  input wire logic sel_uv,
  output logic [31:0] float_product,
  output logic cmp_trip
);
  // multiplier exact for positive power-of-two gains of 1.0 and up, garbage otherwise
  assign float_product = (float_a[22:0] == 23'h0) ?
    float_b + {1'b0, float_a[30:23] - 8'h7f, 23'h0} : ~float_b;
  // overvoltage side trips above the applied level, undervoltage side at or below it
  assign cmp_trip = sel_uv ? (uv_threshold_coef <= target) :
    (ov_threshold_coef > target);
endmodule

// ### dv/measurement_calibration_correction_tb.sv
`timescale 1ns/1ps
module measurement_calibration_correction_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, meas_valid, cmp_trip, sel_uv;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, trim, current_raw, float_a, float_b, float_product, v;
  logic [31:0] cell_raw [5];
  logic [31:0] pin_raw [5];
  logic [15:0] cell_cnt [5];
  logic [15:0] stack_cnt, pack_cnt, load_cnt, adc_cnt;
  logic [7:0] ov_coef, uv_coef, target;
  int fail_count, cmp_count;
  mcc_core uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .meas_valid(meas_valid), .cell_raw_count(cell_raw),
    .cell_offset_trim(trim), .cell_count(cell_cnt), .stack_count(stack_cnt),
    .pack_count(pack_cnt), .load_count(load_cnt), .adc_count(adc_cnt),
    .pin_raw_count(pin_raw), .current_raw(current_raw), .float_a(float_a),
    .float_b(float_b), .float_product(float_product), .ov_threshold_coef(ov_coef),
    .uv_threshold_coef(uv_coef), .cmp_trip(cmp_trip));
  mcc_far_model far (.float_a(float_a), .float_b(float_b), .ov_threshold_coef(ov_coef),
    .uv_threshold_coef(uv_coef), .target(target), .sel_uv(sel_uv),
    .float_product(float_product), .cmp_trip(cmp_trip));
  // clock
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  task automatic end_of_test;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    cmp_count++;
    if (seen !== want) begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, seen, want);
    end
  endtask
  // one bus transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      fail_count++;
      end_of_test;
    end
    v = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rc(input logic [11:0] a, input logic [31:0] want);
    apb(1'b0, a, 32'h0);
    chk(v, want);
  endtask
  task automatic meas;
    @(posedge pclk);
    meas_valid <= 1'b1;
    @(posedge pclk);
    meas_valid <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask
  function automatic logic [31:0] sc(input logic [15:0] g, input logic [15:0] c,
                                     input logic [31:0] o);
    sc = (({16'h0, g} * {16'h0, c}) >> 16) - o;
  endfunction
  // main sequence
  initial begin
    {presetn, psel, penable, pwrite, meas_valid, sel_uv} = 6'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    trim = 32'h0000_0100;
    current_raw = 32'd1000;
    target = 8'h5a;
    {stack_cnt, pack_cnt, load_cnt, adc_cnt} = {16'h4000, 16'h5000, 16'h6000, 16'hffff};
    for (int i = 0; i < 5; i++) begin
      cell_raw[i] = 32'h1000_0000 + 32'(i * 256);
      pin_raw[i] = 32'h0abc_0000 + 32'(i);
      cell_cnt[i] = 16'h8000 + 16'(i * 4096);
    end
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rc(12'hffc, 32'h0);
    apb(1'b1, 12'hffc, 32'h1234_5678);
    rc(12'hffc, 32'h0);
    $display("unmapped access test done");
    // gain readback across the update mode
    apb(1'b1, mcc_pkg::ADDR_CTRL, 32'h1);
    rc(mcc_pkg::ADDR_CELL_GAIN0, 32'h0);
    apb(1'b1, mcc_pkg::ADDR_CELL_GAIN0 + 12'h4, 32'h3000);
    rc(mcc_pkg::ADDR_CELL_GAIN0 + 12'h4, 32'h3000);
    apb(1'b1, mcc_pkg::ADDR_CTRL, 32'h2);
    rc(mcc_pkg::ADDR_CELL_GAIN0, {16'h0, mcc_pkg::CELL_GAIN_NOMINAL});
    rc(mcc_pkg::ADDR_CELL_GAIN0 + 12'h4, 32'h3000);
    $display("gain readback test done");
    // corrected voltages
    apb(1'b1, mcc_pkg::ADDR_VCELL_OFS, 32'hffff_fffb);
    apb(1'b1, mcc_pkg::ADDR_VDIV_OFS, 32'h7);
    apb(1'b1, mcc_pkg::ADDR_STACK_GAIN, 32'h1000);
    apb(1'b1, mcc_pkg::ADDR_PACK_GAIN, 32'h2000);
    apb(1'b1, mcc_pkg::ADDR_LOAD_GAIN, 32'h3000);
    apb(1'b1, mcc_pkg::ADDR_BOARD_OFS, 32'd300);
    apb(1'b1, mcc_pkg::ADDR_OFS_SAMPLES, 32'd3);
    meas;
    for (int i = 0; i < 5; i++) begin
      rc(mcc_pkg::ADDR_CELL_V0 + 12'(4 * i), sc((i == 1) ? 16'h3000 :
         mcc_pkg::CELL_GAIN_NOMINAL, cell_cnt[i], 32'hffff_fffb));
      rc(mcc_pkg::ADDR_CELL_RAW0 + 12'(4 * i), cell_raw[i] - trim);
      rc(mcc_pkg::ADDR_EXT_RAW0 + 12'(4 * i), pin_raw[i]);
    end
    rc(mcc_pkg::ADDR_STACK_V, sc(16'h1000, stack_cnt, 32'h7));
    rc(mcc_pkg::ADDR_PACK_V, sc(16'h2000, pack_cnt, 32'h7));
    rc(mcc_pkg::ADDR_LOAD_V, sc(16'h3000, load_cnt, 32'h7));
    rc(mcc_pkg::ADDR_ADC_V, sc(16'd4040, adc_cnt, 32'h0));
    rc(mcc_pkg::ADDR_READOUT0, {16'h0, stack_cnt});
    rc(mcc_pkg::ADDR_READOUT0 + 12'h4, {16'h0, pack_cnt});
    rc(mcc_pkg::ADDR_READOUT0 + 12'h8, {16'h0, load_cnt});
    $display("voltage test done");
    // current with default and doubled gain
    rc(mcc_pkg::ADDR_CURRENT, 32'd900);
    rc(mcc_pkg::ADDR_CAP_GAIN, mcc_pkg::CAP_GAIN_FACTOR);
    apb(1'b1, mcc_pkg::ADDR_CUR_GAIN, 32'h4000_0000);
    meas;
    rc(mcc_pkg::ADDR_CURRENT, 32'd1800);
    rc(mcc_pkg::ADDR_CAP_GAIN, 32'h4911_a2b4);
    $display("current test done");
    // threshold searches, overvoltage then undervoltage
    for (int s = 0; s < 2; s++) begin
      sel_uv <= s[0];
      target <= s[0] ? 8'h33 : 8'h5a;
      apb(1'b1, mcc_pkg::ADDR_CTRL, s[0] ? 32'h9 : 32'h5);
      for (int n = 0; n <= 20; n++) begin
        if (n == 20) begin
          fail_count++;
          end_of_test;
        end
        apb(1'b0, mcc_pkg::ADDR_STATUS, 32'h0);
        if (v[mcc_pkg::STAT_DONE] === 1'b1 && v[mcc_pkg::STAT_BUSY] === 1'b0) break;
      end
      rc(mcc_pkg::ADDR_CAL_RESULT, {24'h0, target});
      rc(mcc_pkg::ADDR_OV_OVERRIDE + 12'(4 * s), {24'h0, target});
      rc(mcc_pkg::ADDR_OV_IN_USE + 12'(4 * s), {24'h0, target});
      chk({24'h0, s[0] ? uv_coef : ov_coef}, {24'h0, target});
    end
    $display("threshold test done");
    end_of_test;
  end
endmodule
